// *** hw/bst_consts.svh ***
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// Register widths
`define BST_IR_W 8
`define BST_BSR_W 38
`define BST_CTL_W 11
`define BST_GRP_W 16

// Reset and capture values
`define BST_IR_RST 8'hff
`define BST_IR_CAPTURE 8'h81
`define BST_BSR_RST 38'h10_0000_0000
`define BST_CTL_RST 11'h002

// Control register field positions
`define BST_CTL_MASK_HI 10
`define BST_CTL_MASK_LO 3
`define BST_CTL_OP_HI 2
`define BST_CTL_OP_LO 0

// Instruction opcodes, bit 7 keeps even parity
`define BST_OP_EXTEST 8'h00
`define BST_OP_INTEST 8'h03
`define BST_OP_SAMPLE 8'h82
`define BST_OP_HIGHZ 8'h06
`define BST_OP_CLAMP 8'h87
`define BST_OP_RUN_TEST 8'h09
`define BST_OP_READ_NORM 8'h0a
`define BST_OP_READ_TEST 8'h8b
`define BST_OP_SELF_TEST 8'h0c
`define BST_OP_TOGGLE 8'h8d
`define BST_OP_CTRL_NORM 8'h8e
`define BST_OP_CTRL_TEST 8'h0f

// Run-test operation codes held in the control register
`define BST_RUN_PSEUDO_RANDOM_PATTERN_GEN 3'h1
`define BST_RUN_PSA 3'h2
`define BST_RUN_COUNT 3'h3

// Signature and pattern generator feedback taps
`define BST_LFSR_TAPS 16'hd008

// Rising test-clock edges with mode select high that must reach reset
`define BST_TMS_RESET_EDGES 3'h5

`endif

// *** hw/bst_pkg.sv ***
`include "bst_consts.svh"

package bst_pkg;

    // Test access port controller states
    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } bst_tap_e;

    // Data register placed in the scan path
    typedef enum logic [1:0] {DREG_BYPASS, DREG_BSR, DREG_CTL} bst_dreg_e;

    // Source loaded into the cell chain at capture
    typedef enum logic {CAP_PINS, CAP_SHADOW} bst_cap_e;

    // Decoded instruction
    typedef struct packed {
        logic test_mode;
        logic highz;
        logic run_test;
        bst_dreg_e dreg;
        bst_cap_e cap;
    } bst_instr_s;

    // Boundary cell map, bit 37 first
    typedef struct packed {
        logic a_to_b_output_enable;
        logic b_to_a_output_enable_n;
        logic a_to_b_register_clock;
        logic b_to_a_register_clock;
        logic a_to_b_source_select;
        logic b_to_a_source_select;
        logic [7:0] a_in;
        logic [7:0] a_out;
        logic [7:0] b_in;
        logic [7:0] b_out;
    } bst_cells_s;

endpackage : bst_pkg

// *** hw/bst_scan_top.sv ***
`timescale 1ns/100ps
`include "bst_consts.svh"

module bst_scan_top (
    input wire logic REF_CLK, // Block clock, 125 MHz
    input wire logic SRST, // Synchronous reset, active high
    input wire logic TCK, // Test clock pin
    input wire logic TMS, // Test mode select pin
    input wire logic TDI, // Test data in pin
    input wire bst_pkg::bst_cells_s PIN_SAMPLE, // Pin and core levels to capture
    output logic TDO, // Test data out value
    output logic TDO_OE, // High while TDO is driven
    output bst_pkg::bst_cells_s BSR_CELLS, // Boundary shadow latches
    output logic [10:0] CTRL_CELLS, // Control register shadow latches
    output logic TEST_MODE, // Normal function inhibited
    output logic HIGHZ_MODE, // All outputs forced off
    output logic TAP_RESET // Controller in Test-Logic-Reset
);
    import bst_pkg::*;

    // Link synchronisers: first stage is read by the second only
    logic [2:0] link_meta_reg;
    logic [2:0] link_sync_reg;
    logic tck_prev_reg;
    bst_cells_s pin_meta_reg;
    bst_cells_s pin_sync_reg;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;

    bst_tap_e tap_state;
    logic [`BST_IR_W-1:0] ir_shift_reg;
    logic [`BST_IR_W-1:0] ir_shadow_reg;
    logic [`BST_BSR_W-1:0] bsr_shift_reg;
    logic [`BST_BSR_W-1:0] bsr_shadow_reg;
    logic [`BST_CTL_W-1:0] ctl_shift_reg;
    logic [`BST_CTL_W-1:0] ctl_shadow_reg;
    logic bypass_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    bst_instr_s instr;
    logic in_reset;
    logic run_step;

    // Run-test working signals
    logic [`BST_GRP_W-1:0] in_grp;
    logic [`BST_GRP_W-1:0] out_grp;
    logic [`BST_GRP_W-1:0] in_grp_next;
    logic [`BST_GRP_W-1:0] out_grp_next;
    logic [`BST_GRP_W-1:0] masked_in;
    logic [7:0] in_mask;
    logic [2:0] run_op;

    // Opcode decode; anything not listed, bad parity included, runs as bypass
    function automatic bst_instr_s decode_instr(input logic [7:0] op);
        bst_instr_s d;
        d = '{test_mode: 1'b0, highz: 1'b0, run_test: 1'b0, dreg: DREG_BYPASS,
              cap: CAP_PINS};
        case (op)
            `BST_OP_EXTEST, `BST_OP_INTEST: begin
                d.test_mode = 1'b1;
                d.dreg = DREG_BSR;
            end
            `BST_OP_SAMPLE: d.dreg = DREG_BSR;
            `BST_OP_HIGHZ: begin
                d.test_mode = 1'b1;
                d.highz = 1'b1;
            end
            `BST_OP_CLAMP, `BST_OP_TOGGLE: d.test_mode = 1'b1;
            `BST_OP_RUN_TEST: begin
                d.test_mode = 1'b1;
                d.run_test = 1'b1;
            end
            `BST_OP_READ_NORM, `BST_OP_SELF_TEST: begin
                d.dreg = DREG_BSR;
                d.cap = CAP_SHADOW;
            end
            `BST_OP_READ_TEST: begin
                d.test_mode = 1'b1;
                d.dreg = DREG_BSR;
                d.cap = CAP_SHADOW;
            end
            `BST_OP_CTRL_NORM: d.dreg = DREG_CTL;
            `BST_OP_CTRL_TEST: begin
                d.test_mode = 1'b1;
                d.dreg = DREG_CTL;
            end
            default: d.dreg = DREG_BYPASS;
        endcase
        return d;
    endfunction : decode_instr

    // Two flops on every pin before use
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            link_meta_reg <= 3'h3; // Clock bit at its idle low, so no false edge
            link_sync_reg <= 3'h3;
            tck_prev_reg <= 1'b0;
        end else begin
            link_meta_reg <= {TCK, TMS, TDI};
            link_sync_reg <= link_meta_reg;
            tck_prev_reg <= link_sync_reg[2];
        end
    end

    // Captured pins pass the same two stages
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= PIN_SAMPLE;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign tck_s = link_sync_reg[2];
    assign tms_s = link_sync_reg[1];
    assign tdi_s = link_sync_reg[0];
    assign tck_rise = tck_s & ~tck_prev_reg;
    assign tck_fall = ~tck_s & tck_prev_reg;

    bst_tap_fsm u_tap (
        .clk(REF_CLK),
        .rst(SRST),
        .step(tck_rise),
        .tms(tms_s),
        .state(tap_state)
    );

    assign in_reset = (tap_state == TAP_TLR);
    assign instr = decode_instr(ir_shadow_reg);

    // Instruction shift stage: capture fixed pattern, shift after entry
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            ir_shift_reg <= `BST_IR_RST;
        end else if (tck_rise) begin
            if (tap_state == TAP_CAP_IR) begin
                ir_shift_reg <= `BST_IR_CAPTURE;
            end else if (tap_state == TAP_SHIFT_IR) begin
                ir_shift_reg <= {tdi_s, ir_shift_reg[`BST_IR_W-1:1]};
            end
        end
    end

    // Instruction shadow: new mode takes effect on the Update-IR falling edge
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            ir_shadow_reg <= `BST_IR_RST;
        end else if (tck_fall && tap_state == TAP_UPD_IR) begin
            ir_shadow_reg <= ir_shift_reg;
        end
    end

    // Boundary shift stage; pause and exit states leave it untouched
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            bsr_shift_reg <= `BST_BSR_RST;
        end else if (tck_rise && instr.dreg == DREG_BSR) begin
            if (tap_state == TAP_CAP_DR) begin
                bsr_shift_reg <= (instr.cap == CAP_PINS) ? pin_sync_reg
                                                         : bsr_shadow_reg;
            end else if (tap_state == TAP_SHIFT_DR) begin
                bsr_shift_reg <= {tdi_s, bsr_shift_reg[`BST_BSR_W-1:1]};
            end
        end
    end

    // Run-test groups: A then B, pin 8 highest in each
    assign in_grp = {bsr_shadow_reg[31:24], bsr_shadow_reg[15:8]};
    assign out_grp = {bsr_shadow_reg[23:16], bsr_shadow_reg[7:0]};
    assign in_mask = ctl_shadow_reg[`BST_CTL_MASK_HI:`BST_CTL_MASK_LO];
    assign run_op = ctl_shadow_reg[`BST_CTL_OP_HI:`BST_CTL_OP_LO];
    assign masked_in = {pin_sync_reg.a_in & ~in_mask, pin_sync_reg.b_in & ~in_mask};
    assign run_step = tck_rise && tap_state == TAP_RTI && instr.run_test;

    // Run-test operation on the shadow groups; masked channels add nothing
    always_comb begin
        in_grp_next = in_grp;
        out_grp_next = out_grp;
        case (run_op)
            `BST_RUN_PSA: begin
                in_grp_next = {in_grp[14:0], ^(in_grp & `BST_LFSR_TAPS)} ^ masked_in;
            end
            `BST_RUN_PSEUDO_RANDOM_PATTERN_GEN: begin
                out_grp_next = {out_grp[14:0], ~^(out_grp & `BST_LFSR_TAPS)};
            end
            `BST_RUN_COUNT: begin
                out_grp_next = out_grp + 16'h0001;
            end
            default: begin
                in_grp_next = in_grp;
            end
        endcase
    end

    // Boundary shadow: update at Update-DR fall, may also move in Run-Test/Idle
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            bsr_shadow_reg <= `BST_BSR_RST;
        end else if (tck_fall && tap_state == TAP_UPD_DR && instr.dreg == DREG_BSR) begin
            bsr_shadow_reg <= bsr_shift_reg;
        end else if (run_step) begin
            bsr_shadow_reg[31:24] <= in_grp_next[15:8];
            bsr_shadow_reg[15:8] <= in_grp_next[7:0];
            bsr_shadow_reg[23:16] <= out_grp_next[15:8];
            bsr_shadow_reg[7:0] <= out_grp_next[7:0];
        end
    end

    // Control shift stage: capture leaves it as it was
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            ctl_shift_reg <= `BST_CTL_RST;
        end else if (tck_rise && instr.dreg == DREG_CTL
                     && tap_state == TAP_SHIFT_DR) begin
            ctl_shift_reg <= {tdi_s, ctl_shift_reg[`BST_CTL_W-1:1]};
        end
    end

    // Control shadow: update only at the Update-DR falling edge
    always_ff @(posedge REF_CLK) begin
        if (SRST || in_reset) begin
            ctl_shadow_reg <= `BST_CTL_RST;
        end else if (tck_fall && tap_state == TAP_UPD_DR && instr.dreg == DREG_CTL) begin
            ctl_shadow_reg <= ctl_shift_reg;
        end
    end

    // Bypass: single shift stage, no shadow
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            bypass_reg <= 1'b0;
        end else if (tck_rise && instr.dreg == DREG_BYPASS) begin
            if (tap_state == TAP_CAP_DR) begin
                bypass_reg <= 1'b0;
            end else if (tap_state == TAP_SHIFT_DR) begin
                bypass_reg <= tdi_s;
            end
        end
    end

    // TDO moves on the falling edge so the far end samples a settled level
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_reg <= (tap_state == TAP_SHIFT_IR)
                          || (tap_state == TAP_SHIFT_DR);
            if (tap_state == TAP_SHIFT_IR) begin
                tdo_reg <= ir_shift_reg[0];
            end else if (tap_state == TAP_SHIFT_DR) begin
                case (instr.dreg)
                    DREG_BSR: tdo_reg <= bsr_shift_reg[0];
                    DREG_CTL: tdo_reg <= ctl_shift_reg[0];
                    default: tdo_reg <= bypass_reg;
                endcase
            end
        end
    end

    assign TDO = tdo_reg;
    assign TDO_OE = tdo_oe_reg;
    assign BSR_CELLS = bsr_shadow_reg;
    assign CTRL_CELLS = ctl_shadow_reg;
    assign TEST_MODE = instr.test_mode;
    assign HIGHZ_MODE = instr.highz;
    assign TAP_RESET = in_reset;

    // Checks below; helper counter only feeds them
    logic [2:0] tms_hi_cnt_reg;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            tms_hi_cnt_reg <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_hi_cnt_reg <= 3'h0;
            end else if (tms_hi_cnt_reg != `BST_TMS_RESET_EDGES) begin
                tms_hi_cnt_reg <= tms_hi_cnt_reg + 3'h1;
            end
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    chk_capture_ir_value: assert property (
        (tap_state == TAP_CAP_IR && tck_rise) |=> ir_shift_reg == `BST_IR_CAPTURE)
        else $error("Capture-IR pattern not loaded");

    chk_ir_reset_ones: assert property (
        in_reset |=> (ir_shadow_reg == `BST_IR_RST && !TEST_MODE))
        else $error("Instruction not reset to bypass");

    chk_tdo_release: assert property (
        ((tap_state == TAP_EXIT1_DR || tap_state == TAP_EXIT1_IR) && tck_fall)
        |=> !TDO_OE)
        else $error("TDO still driven after Exit1");

    chk_tdo_ir_lsb: assert property (
        (tap_state == TAP_SHIFT_IR && tck_fall)
        |=> (TDO_OE && TDO == $past(ir_shift_reg[0])))
        else $error("TDO does not show instruction LSB");

    chk_ir_update_copy: assert property (
        (tap_state == TAP_UPD_IR && tck_fall) |=> ir_shadow_reg == $past(ir_shift_reg))
        else $error("Instruction shadow not updated");

    chk_ctl_capture_hold: assert property (
        (tap_state == TAP_CAP_DR && tck_rise && instr.dreg == DREG_CTL)
        |=> $stable(ctl_shift_reg))
        else $error("Control register changed at capture");

    chk_bypass_zero: assert property (
        (tap_state == TAP_CAP_DR && tck_rise && instr.dreg == DREG_BYPASS)
        |=> !bypass_reg)
        else $error("Bypass did not capture zero");

    chk_pause_ir_hold: assert property (
        (tap_state == TAP_PAUSE_IR) |=> $stable(ir_shift_reg))
        else $error("Instruction lost in Pause-IR");

    chk_bsr_shift_dir: assert property (
        (tap_state == TAP_SHIFT_DR && tck_rise && instr.dreg == DREG_BSR)
        |=> bsr_shift_reg == {$past(tdi_s), $past(bsr_shift_reg[37:1])})
        else $error("Boundary chain shifted wrongly");

    chk_bsr_reset_val: assert property (
        in_reset |=> bsr_shadow_reg == `BST_BSR_RST)
        else $error("Boundary cells not at reset value");

    chk_tms_reset_reach: assert property (
        (tms_hi_cnt_reg == `BST_TMS_RESET_EDGES) |-> in_reset)
        else $error("Five TMS-high edges did not reach reset");

endmodule : bst_scan_top

// *** hw/bst_tap_fsm.sv ***
`timescale 1ns/100ps

module bst_tap_fsm (
    input wire logic clk, // Block clock
    input wire logic rst, // Synchronous reset
    input wire logic step, // One pulse per rising test-clock edge
    input wire logic tms, // Sampled mode select
    output bst_pkg::bst_tap_e state // Present controller state
);
    import bst_pkg::*;

    bst_tap_e state_reg;
    bst_tap_e state_next;

    assign state = state_reg;

    // Next state from mode select; exits may return to shift without capture
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TAP_TLR: state_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: state_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: state_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: state_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: state_next = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: state_next = tms ? TAP_SEL_DR : TAP_RTI;
        endcase
    end

    // State moves only on a rising test-clock edge
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= TAP_TLR;
        end else if (step) begin
            state_reg <= state_next;
        end
    end

endmodule : bst_tap_fsm

// *** verification/boundary_scan_test_registers_bench.sv ***
`timescale 1ns/100ps
`include "bst_consts.svh"

// Scan logic driven through its test port by the controller model
module boundary_scan_test_registers_bench;
    import bst_pkg::*;
    localparam logic [37:0] PINS = 38'h2b_3c4d_5e6f;
    localparam logic [63:0] CELLS = 64'h15_a5c3_9e0f;
    // Opcode, then expected test mode and high-impedance mode
    localparam logic [9:0] OPS [14] = '{{8'h00, 2'b10}, {8'h03, 2'b10}, {8'h82, 2'b00},
        {8'h06, 2'b11}, {8'h87, 2'b10}, {8'h09, 2'b10}, {8'h0a, 2'b00}, {8'h8b, 2'b10},
        {8'h0c, 2'b00}, {8'h8d, 2'b10}, {8'h8e, 2'b00}, {8'h0f, 2'b10}, {8'h95, 2'b00},
        {8'h81, 2'b00}};
    logic REF_CLK, SRST, TCK, TMS, TDI, TDO, TDO_OE, TEST_MODE, HIGHZ_MODE, TAP_RESET;
    bst_cells_s PIN_SAMPLE, BSR_CELLS;
    logic [10:0] CTRL_CELLS;
    logic [63:0] dout, oes;
    logic oe_after;
    int err_total = 0;
    int comparisons = 0;

    bst_scan_top DUT (.REF_CLK(REF_CLK), .SRST(SRST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
        .PIN_SAMPLE(PIN_SAMPLE), .TDO(TDO), .TDO_OE(TDO_OE), .BSR_CELLS(BSR_CELLS),
        .CTRL_CELLS(CTRL_CELLS), .TEST_MODE(TEST_MODE), .HIGHZ_MODE(HIGHZ_MODE),
        .TAP_RESET(TAP_RESET));

    bst_tap_master ctl (.tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO), .tdo_oe(TDO_OE));

    // Block clock
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Scan and check data out, the drive window and the release after it
    task automatic scan_chk(input logic ir, input int n, input logic [63:0] din, input int hold,
                            input logic [63:0] exp);
        logic [63:0] mask;
        mask = (64'h1 << n) - 64'h1;
        ctl.scan(ir, n, din, hold, dout, oes, oe_after);
        chk("scan out", exp, dout & mask);
        chk("drive window", mask, oes & mask);
        chk("release", 64'h0, {63'h0, oe_after});
    endtask : scan_chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Hang guard, well above the few hundred test clocks the run needs
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    // Main sequence
    initial begin
        SRST = 1'b1;
        PIN_SAMPLE = '0;
        repeat (16) @(posedge REF_CLK);
        SRST <= 1'b0;
        PIN_SAMPLE <= PINS;
        repeat (4) @(posedge REF_CLK);
        chk("tap reset", 64'h1, {63'h0, TAP_RESET});
        chk("cells", {26'h0, `BST_BSR_RST}, {26'h0, BSR_CELLS});
        chk("control", {53'h0, `BST_CTL_RST}, {53'h0, CTRL_CELLS});
        chk("modes", 64'h0, {62'h0, TEST_MODE, HIGHZ_MODE});
        ctl.reset_tap();
        chk("tap left reset", 64'h0, {63'h0, TAP_RESET});
        // Control register keeps its value at capture and survives a pause
        scan_chk(1'b1, 8, `BST_OP_CTRL_NORM, 99, 64'h81);
        scan_chk(1'b0, 11, 64'h5a5, 4, 64'h002);
        chk("control shadow", 64'h5a5, {53'h0, CTRL_CELLS});
        scan_chk(1'b0, 11, 64'h002, 99, 64'h5a5);
        // Boundary chain captures the pins, then reads back its shadow
        scan_chk(1'b1, 8, `BST_OP_EXTEST, 99, 64'h81);
        chk("test mode", 64'h1, {63'h0, TEST_MODE});
        scan_chk(1'b0, 38, CELLS, 20, {26'h0, PINS});
        chk("cell shadow", CELLS, {26'h0, BSR_CELLS});
        chk("cell fields", 64'h1a50f, {47'h0, BSR_CELLS.b_to_a_output_enable_n,
            BSR_CELLS.a_in, BSR_CELLS.b_out});
        scan_chk(1'b1, 8, `BST_OP_READ_NORM, 99, 64'h81);
        scan_chk(1'b0, 38, 64'h0, 99, CELLS);
        // Back to reset with mode select high
        ctl.reset_tap();
        chk("cells after reset", {26'h0, `BST_BSR_RST}, {26'h0, BSR_CELLS});
        chk("control after reset", 64'h002, {53'h0, CTRL_CELLS});
        chk("modes after reset", 64'h0, {62'h0, TEST_MODE, HIGHZ_MODE});
        scan_chk(1'b0, 4, 64'hb, 99, 64'h6);
        // Every listed opcode plus two unlisted ones, parity already set in the table
        for (int k = 0; k < 14; k++) begin
            scan_chk(1'b1, 8, {56'h0, OPS[k][9:2]}, 99, 64'h81);
            chk("mode pair", {62'h0, OPS[k][1:0]}, {62'h0, TEST_MODE, HIGHZ_MODE});
        end
        scan_chk(1'b0, 4, 64'h5, 99, 64'ha);
        // Count up the output cells: two idle rises plus the one leaving idle
        scan_chk(1'b1, 8, `BST_OP_CTRL_NORM, 99, 64'h81);
        scan_chk(1'b0, 11, 64'h003, 99, 64'h002);
        scan_chk(1'b1, 8, `BST_OP_EXTEST, 99, 64'h81);
        scan_chk(1'b0, 38, CELLS, 99, {26'h0, PINS});
        scan_chk(1'b1, 8, `BST_OP_RUN_TEST, 99, 64'h81);
        repeat (2) begin
            ctl.pulse(1'b0, 1'b1, dout[0], oe_after);
            chk("idle release", 64'h0, {63'h0, oe_after});
        end
        // Instruction scan parked in pause, then read the counted shadow
        scan_chk(1'b1, 8, `BST_OP_READ_NORM, 3, 64'h81);
        scan_chk(1'b0, 38, 64'h0, 99, 64'h15_a5c3_9e12);
        wrap_up();
    end
endmodule : boundary_scan_test_registers_bench

// *** verification/bst_tap_master.sv ***
`timescale 1ns/100ps

// Behavioural test bus controller; the link clock runs only inside frames
module bst_tap_master (
    output logic tck, // Test clock to the device
    output logic tms, // Mode select, pulled high when idle
    output logic tdi, // Data in, pulled high when idle
    input wire logic tdo, // Device serial out
    input wire logic tdo_oe // Device drive enable
);
    localparam real HALF = 62.5;

    // Idle levels follow the pin pull-ups, clock rests low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One clock: present mode and data at the fall, sample the device before the rise
    task automatic pulse(input logic m, input logic d, output logic q, output logic oe);
        tms <= m;
        tdi <= d;
        #(HALF);
        q = tdo;
        oe = tdo_oe;
        tck <= 1'b1;
        #(HALF);
        tck <= 1'b0;
    endtask : pulse

    // Mode select held high reaches reset, then step to idle
    task automatic reset_tap();
        logic q, oe;
        repeat (5) pulse(1'b1, 1'b1, q, oe);
        pulse(1'b0, 1'b1, q, oe);
    endtask : reset_tap

    // Scan from idle back to idle, optionally parking in pause after bit hold
    task automatic scan(input logic ir, input int n, input logic [63:0] din, input int hold,
                        output logic [63:0] dout, output logic [63:0] oes, output logic oe_after);
        logic q, oe;
        dout = '0;
        oes = '0;
        oe_after = 1'b0;
        pulse(1'b1, 1'b1, q, oe);
        if (ir) pulse(1'b1, 1'b1, q, oe);
        pulse(1'b0, 1'b1, q, oe);
        pulse(1'b0, 1'b1, q, oe);
        oe_after |= oe;
        for (int i = 0; i < n; i++) begin
            pulse(logic'(i == n - 1 || i == hold), din[i], q, oe);
            dout[i] = q;
            oes[i] = oe;
            if (i == hold) begin
                pulse(1'b0, 1'b1, q, oe);
                oe_after |= oe;
                pulse(1'b0, 1'b1, q, oe);
                oe_after |= oe;
                pulse(1'b1, 1'b1, q, oe);
                pulse(1'b0, 1'b1, q, oe);
            end
        end
        pulse(1'b1, 1'b1, q, oe);
        oe_after |= oe;
        pulse(1'b0, 1'b1, q, oe);
        oe_after |= oe;
    endtask : scan
endmodule : bst_tap_master
